// ===== common/cvs_defines.vh
`ifndef CVS_DEFINES_VH
`define CVS_DEFINES_VH

// register addresses carried in the command byte
`define CVS_ADDR_STATUS  6'h00
`define CVS_ADDR_IFMODE  6'h02
`define CVS_ADDR_DATA    6'h04

// command byte fields
`define CVS_CMD_WEN      7
`define CVS_CMD_RW       6

// status byte layout and reset value
`define CVS_STATUS_RST   8'h80
`define CVS_ST_RDY       7
`define CVS_ST_ADCERR    6
`define CVS_ST_CRCERR    5
`define CVS_ST_REGERR    4

// interface mode word layout and reset value
`define CVS_IFMODE_RST   16'h0000
`define CVS_IFM_APPEND   6
`define CVS_IFM_CHECK    5
`define CVS_IFM_CRCEN    2

// clamp values for out-of-range results
`define CVS_CLAMP_HI     24'hffffff
`define CVS_CLAMP_LO     24'h000000

// write check polynomial and frame lengths in bits
`define CVS_CRC_POLY     8'h07
`define CVS_LEN_BYTE     6'h08
`define CVS_LEN_WORD     6'h10
`define CVS_LEN_DATA     6'h18
`define CVS_LEN_DATAST   6'h20

`endif

// ===== rtl/cvs_sync.v
`timescale 1ns/1ns
`default_nettype none
// pin filter: three stage flops and an output flop, a change counts once stages two and three agree
module cvs_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clock,   // system clock
  input  wire rst_n,   // async reset, active low
  input  wire pin_i,   // raw pin level
  output reg  level_o  // filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cvs_crc8.v
`timescale 1ns/1ns
`default_nettype none
`include "cvs_defines.vh"
// bit-serial check value, msb first; start_i restarts from zero
module cvs_crc8 (
  input  wire       clock,    // system clock
  input  wire       rst_n,    // async reset, active low
  input  wire       bit_en_i, // one bit arrives this cycle
  input  wire       start_i,  // bit is the first of a frame
  input  wire       bit_i,    // serial bit
  output reg  [7:0] crc_o     // running check value
);
  wire [7:0] base;
  wire       fb;

  assign base = start_i ? 8'h00 : crc_o;
  assign fb   = base[7] ^ bit_i;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc_o <= 8'h00;
    end else if (bit_en_i) begin
      crc_o <= {base[6:0], 1'b0} ^ (fb ? `CVS_CRC_POLY : 8'h00);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cvs_status_top.v
//  Operation
// - status is an 8-bit read-only register at address 0, reset 0x80
// - with append enabled, status byte follows the data word on data reads
// - ready flag drives the output pin while selected and no read runs
// - ready flag clears when a new conversion result is stored
// - in calibration mode, ready clears when the calibration result is stored
// - ready flag sets again when a data register read completes
// - range fault bit 6 reports overrange or underrange of a result
// - overrange stores 0xffffff, underrange stores 0x000000
// - range fault updates only on result writes, clears on next clean result
// - write check fault bit 5 sets on a write with failing check byte
// - any status register read clears the write check fault
// - drift bit 4 sets when register sum leaves its captured reference
// - setting the check enable captures the reference and starts monitoring
// - drift clears only when the check enable is cleared, not on reads
// - bits 3:0 hold the channel of the stored result, 0 to 15
`timescale 1ns/1ns
`default_nettype none
`include "cvs_defines.vh"
module cvs_status_top (
  input  wire        clock,       // 10 MHz system clock
  input  wire        rst_n,       // async reset, active low
  input  wire        sclk_i,      // serial clock pin, idles high
  input  wire        cs_n_i,      // chip select pin, active low
  input  wire        din_i,       // serial data in pin
  output reg         dout_o,      // serial data out / ready pin
  output wire        dout_oe,     // pin drive enable, high while selected
  input  wire        res_wr,      // conversion result strobe
  input  wire [23:0] res_data,    // raw conversion result
  input  wire [3:0]  res_chan,    // channel of the result
  input  wire        res_over,    // result overranged
  input  wire        res_under,   // result underranged
  input  wire        cal_mode,    // converter is calibrating
  input  wire        cal_wr,      // calibration result strobe
  input  wire [15:0] reg_sum,     // running sum over internal registers
  output wire [7:0]  status_o,    // current status byte
  output reg  [23:0] data_o,      // stored result
  output wire        append_en_o, // append status enable
  output wire        check_en_o,  // register check enable
  output wire        crc_en_o     // write check enable
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CMD  = 6'h02;
  localparam [5:0] ST_RD   = 6'h04;
  localparam [5:0] ST_WR   = 6'h08;
  localparam [5:0] ST_CRC  = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;
  localparam [7:0] STATUS_RST_W = `CVS_STATUS_RST;

  // ----------------------------------------------------------------
  // pin filters and edges
  // ----------------------------------------------------------------
  wire sclk_s;
  wire csn_s;
  wire din_s;

  cvs_sync #(.RST_VAL(1'b1)) u_sync_sclk (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin_i   (sclk_i),
    .level_o (sclk_s)
  );
  cvs_sync #(.RST_VAL(1'b1)) u_sync_csn (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin_i   (cs_n_i),
    .level_o (csn_s)
  );
  cvs_sync #(.RST_VAL(1'b0)) u_sync_din (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin_i   (din_i),
    .level_o (din_s)
  );

  reg        sclk_q_r;
  reg  [5:0] st_r;
  reg  [5:0] cnt_r;
  reg  [5:0] len_r;
  reg  [5:0] addr_r;
  reg  [6:0] cmd_sh_r;
  reg  [15:0] rx_sh_r;
  reg  [15:0] wdata_r;
  reg  [31:0] tx_sh_r;
  reg  [15:0] ifmode_r;
  reg  [15:0] ref_r;
  reg        armed_r;
  reg        rdy_r;
  reg        aerr_r;
  reg        crc_err_r;
  reg        drift_r;
  reg  [3:0] chan_r;
  wire [7:0] crc_val;

  wire rise = sclk_s & ~sclk_q_r;
  wire fall = ~sclk_s & sclk_q_r;

  assign dout_oe     = ~csn_s;
  assign append_en_o = ifmode_r[`CVS_IFM_APPEND];
  assign check_en_o  = ifmode_r[`CVS_IFM_CHECK];
  assign crc_en_o    = ifmode_r[`CVS_IFM_CRCEN];
  assign status_o    = {rdy_r, aerr_r, crc_err_r, drift_r, chan_r};

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  wire [7:0]  cmd_b    = {cmd_sh_r, din_s};
  wire [15:0] wr_b     = {rx_sh_r[14:0], din_s};
  wire [7:0]  crc_b    = {rx_sh_r[6:0], din_s};
  wire        cmd_done = (st_r == ST_CMD) & rise & (cnt_r == 6'h07);
  wire        cmd_ok   = cmd_done & ~cmd_b[`CVS_CMD_WEN];
  wire        rd_start = cmd_ok & cmd_b[`CVS_CMD_RW];
  wire        snap     = rd_start & (cmd_b[5:0] == `CVS_ADDR_STATUS);
  wire        rd_done  = (st_r == ST_RD) & rise & (cnt_r == len_r - 6'h01);
  wire        data_done = rd_done & (addr_r == `CVS_ADDR_DATA);
  wire        wr_end   = (st_r == ST_WR) & rise & (cnt_r == `CVS_LEN_WORD - 6'h01);
  wire        crc_end  = (st_r == ST_CRC) & rise & (cnt_r == `CVS_LEN_BYTE - 6'h01);
  wire        crc_ok   = (crc_b == crc_val);
  wire        apply    = (wr_end & ~crc_en_o) | (crc_end & crc_ok);
  wire        crc_fail = crc_end & ~crc_ok;
  wire [15:0] apply_w  = crc_end ? wdata_r : wr_b;
  wire        new_res  = cal_mode ? cal_wr : res_wr;
  wire        crc_bit  = rise & ((st_r == ST_CMD) | (st_r == ST_WR));

  // read length in bits for the addressed register
  function [5:0] rd_len;
    input [5:0] a;
    input       app;
    begin
      if (a == `CVS_ADDR_DATA) begin
        rd_len = app ? `CVS_LEN_DATAST : `CVS_LEN_DATA;
      end else if (a == `CVS_ADDR_IFMODE) begin
        rd_len = `CVS_LEN_WORD;
      end else begin
        rd_len = `CVS_LEN_BYTE;
      end
    end
  endfunction

  cvs_crc8 u_crc (
    .clock    (clock),
    .rst_n    (rst_n),
    .bit_en_i (crc_bit),
    .start_i  ((st_r == ST_CMD) & (cnt_r == 6'h00)),
    .bit_i    (din_s),
    .crc_o    (crc_val)
  );

  // ----------------------------------------------------------------
  // status flags and result store
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r     <= STATUS_RST_W[`CVS_ST_RDY];
      aerr_r    <= 1'b0;
      crc_err_r <= 1'b0;
      drift_r   <= 1'b0;
      chan_r    <= 4'h0;
      data_o    <= 24'h000000;
      ifmode_r  <= `CVS_IFMODE_RST;
      ref_r     <= 16'h0000;
      armed_r   <= 1'b0;
    end else begin
      if (res_wr && !cal_mode) begin
        aerr_r <= res_over | res_under;
        chan_r <= res_chan;
        if (res_over) begin
          data_o <= `CVS_CLAMP_HI;
        end else if (res_under) begin
          data_o <= `CVS_CLAMP_LO;
        end else begin
          data_o <= res_data;
        end
      end
      // a new result wins over the read that would set the flag
      if (new_res) begin
        rdy_r <= 1'b0;
      end else if (data_done) begin
        rdy_r <= 1'b1;
      end
      if (crc_fail) begin
        crc_err_r <= 1'b1;
      end else if (snap) begin
        crc_err_r <= 1'b0;
      end
      if (apply) begin
        ifmode_r <= apply_w;
        if (apply_w[`CVS_IFM_CHECK] && !ifmode_r[`CVS_IFM_CHECK]) begin
          ref_r   <= reg_sum;
          armed_r <= 1'b1;
        end else if (!apply_w[`CVS_IFM_CHECK]) begin
          armed_r <= 1'b0;
        end
      end
      if (!ifmode_r[`CVS_IFM_CHECK]) begin
        drift_r <= 1'b0;
      end else if (armed_r && (reg_sum != ref_r)) begin
        drift_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b1;
      st_r     <= ST_IDLE;
      cnt_r    <= 6'h00;
      len_r    <= `CVS_LEN_BYTE;
      addr_r   <= 6'h00;
      cmd_sh_r <= 7'h00;
      rx_sh_r  <= 16'h0000;
      wdata_r  <= 16'h0000;
      tx_sh_r  <= 32'h00000000;
      dout_o   <= 1'b1;
    end else begin
      sclk_q_r <= sclk_s;
      if (st_r != ST_RD) begin
        dout_o <= rdy_r;
      end
      if (csn_s) begin
        st_r  <= ST_IDLE;
        cnt_r <= 6'h00;
      end else begin
        case (st_r)
          ST_IDLE: begin
            st_r  <= ST_CMD;
            cnt_r <= 6'h00;
          end
          ST_CMD: begin
            if (rise) begin
              cmd_sh_r <= cmd_b[6:0];
              cnt_r    <= cnt_r + 6'h01;
              if (cmd_done) begin
                cnt_r  <= 6'h00;
                addr_r <= cmd_b[5:0];
                if (cmd_b[`CVS_CMD_WEN]) begin
                  st_r <= ST_CMD;
                end else if (rd_start) begin
                  st_r  <= ST_RD;
                  len_r <= rd_len(cmd_b[5:0], append_en_o);
                  case (cmd_b[5:0])
                    `CVS_ADDR_STATUS: tx_sh_r <= {status_o, 24'h000000};
                    `CVS_ADDR_DATA:   tx_sh_r <= {data_o, status_o};
                    `CVS_ADDR_IFMODE: tx_sh_r <= {ifmode_r, 16'h0000};
                    default:          tx_sh_r <= 32'h00000000;
                  endcase
                end else if (cmd_b[5:0] == `CVS_ADDR_IFMODE) begin
                  st_r <= ST_WR;
                end else begin
                  st_r <= ST_SKIP;
                end
              end
            end
          end
          ST_RD: begin
            if (fall) begin
              dout_o  <= tx_sh_r[31];
              tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            end
            if (rise) begin
              cnt_r <= cnt_r + 6'h01;
              if (rd_done) begin
                cnt_r <= 6'h00;
                st_r  <= ST_CMD;
              end
            end
          end
          ST_WR: begin
            if (rise) begin
              rx_sh_r <= wr_b;
              cnt_r   <= cnt_r + 6'h01;
              if (wr_end) begin
                cnt_r   <= 6'h00;
                wdata_r <= wr_b;
                st_r    <= crc_en_o ? ST_CRC : ST_CMD;
              end
            end
          end
          ST_CRC: begin
            if (rise) begin
              rx_sh_r <= wr_b;
              cnt_r   <= cnt_r + 6'h01;
              if (crc_end) begin
                cnt_r <= 6'h00;
                st_r  <= ST_CMD;
              end
            end
          end
          ST_SKIP: begin
            st_r <= ST_SKIP;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/cvs_status_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cvs_status_chk (
  input wire logic        clock,      // system clock
  input wire logic        rst_n,      // async reset
  input wire logic        res_wr,     // result strobe
  input wire logic [3:0]  res_chan,   // result channel
  input wire logic        res_over,   // overrange
  input wire logic        res_under,  // underrange
  input wire logic        cal_mode,   // calibrating
  input wire logic        cal_wr,     // cal strobe
  input wire logic        check_en_o, // check enable
  input wire logic [7:0]  status_o,   // status byte
  input wire logic [23:0] data_o      // stored result
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------
  // result and calibration writes
  // ---------------------------------
  sequence s_res;
    res_wr && !cal_mode;
  endsequence
  sequence s_cal;
    cal_mode && cal_wr;
  endsequence
  a_reset_value: assert property ($rose(rst_n) |-> status_o == 8'h80)
    else $error("status reset value wrong");
  a_ready_clear: assert property ((s_res or s_cal) |=> !status_o[7])
    else $error("ready not cleared by new result");
  a_cal_ignored: assert property (cal_mode && res_wr && !cal_wr && status_o[7]
    |=> status_o[7] && $stable(data_o)) else $error("result taken in cal mode");
  a_range_flag: assert property (s_res |=> status_o[6] == $past(res_over || res_under))
    else $error("range flag wrong");
  a_range_hold: assert property (!res_wr |=> $stable(status_o[6]))
    else $error("range flag moved without result");
  a_clamp_high: assert property (s_res ##0 res_over |=> data_o == 24'hffffff)
    else $error("overrange not clamped");
  a_clamp_low: assert property (s_res ##0 (res_under && !res_over) |=> data_o == 24'h000000)
    else $error("underrange not clamped");
  a_chan_load: assert property (s_res |=> status_o[3:0] == $past(res_chan))
    else $error("channel field wrong");
  a_drift_hold: assert property (status_o[4] && check_en_o |=> status_o[4] || !check_en_o)
    else $error("drift flag dropped");
  a_drift_clear: assert property ($fell(check_en_o) |-> ##[0:2] !status_o[4])
    else $error("drift flag kept after disable");
endmodule
bind cvs_status_top cvs_status_chk u_chk (
  .clock(clock), .rst_n(rst_n), .res_wr(res_wr), .res_chan(res_chan),
  .res_over(res_over), .res_under(res_under), .cal_mode(cal_mode), .cal_wr(cal_wr),
  .check_en_o(check_en_o), .status_o(status_o), .data_o(data_o)
);
`default_nettype wire

// ===== test/cvs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cvs_host_model (
  input  wire logic clock,  // system clock
  output var  logic sclk,   // serial clock, idles high
  output var  logic cs_n,   // chip select
  output var  logic din,    // data to device
  input  wire logic dout,   // data / ready from device
  input  wire logic dout_oe // device drives dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one frame, n bits msb first, each sclk level held 8 clocks
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    cs_n = 1'b0;
    wait_clk(6);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      wait_clk(8);
      // reply bit; reads carry no check byte to verify
      rx = {rx[38:0], dout_oe ? dout : 1'bx};
      sclk = 1'b1;
      wait_clk(8);
    end
    cs_n = 1'b1;
    din = ~din;
    wait_clk(6);
  endtask
endmodule
`default_nettype wire

// ===== test/tb_converter_status_flags.sv
`timescale 1ns/1ns
`default_nettype none
module tb_converter_status_flags;
  typedef struct packed {
    logic        ov;
    logic        un;
    logic [23:0] d;
    logic [3:0]  ch;
    logic [23:0] ed;
    logic [7:0]  es;
  } cvs_row_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        res_wr = 1'b0;
  logic        res_over = 1'b0;
  logic        res_under = 1'b0;
  logic        cal_mode = 1'b0;
  logic        cal_wr = 1'b0;
  logic [23:0] res_data = 24'h000000;
  logic [3:0]  res_chan = 4'h0;
  logic [15:0] reg_sum = 16'h1234;
  logic [39:0] rx;
  wire         sclk, cs_n, din, dout_o, dout_oe, append_en_o, check_en_o, crc_en_o;
  wire  [7:0]  status_o;
  wire  [23:0] data_o;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  cvs_row_t    rows [5] = '{
    '{1'b0, 1'b0, 24'h123456, 4'h3, 24'h123456, 8'h03},
    '{1'b1, 1'b0, 24'h345678, 4'hf, 24'hffffff, 8'h4f},
    '{1'b0, 1'b1, 24'h345678, 4'h0, 24'h000000, 8'h40},
    '{1'b1, 1'b1, 24'h345678, 4'h7, 24'hffffff, 8'h47},
    '{1'b0, 1'b0, 24'habcdef, 4'ha, 24'habcdef, 8'h0a}};
  cvs_status_top DUT (
    .clock(clock), .rst_n(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout_o), .dout_oe(dout_oe), .res_wr(res_wr), .res_data(res_data),
    .res_chan(res_chan), .res_over(res_over), .res_under(res_under),
    .cal_mode(cal_mode), .cal_wr(cal_wr), .reg_sum(reg_sum), .status_o(status_o),
    .data_o(data_o), .append_en_o(append_en_o), .check_en_o(check_en_o),
    .crc_en_o(crc_en_o));
  cvs_host_model host (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_o),
    .dout_oe(dout_oe));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk_st(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put_res(input cvs_row_t r);
    res_over = r.ov;
    res_under = r.un;
    res_data = r.d;
    res_chan = r.ch;
    res_wr = 1'b1;
    @(negedge clock);
    res_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    chk_st(status_o, 8'h80);
    chk_st({6'h00, dout_oe, dout_o}, 8'h01);
    foreach (rows[i]) begin
      put_res(rows[i]);
      chk_dat({8'h00, data_o}, {8'h00, rows[i].ed});
      chk_st(status_o, rows[i].es);
    end
    host.xfer(40'h4000, 16, rx);
    chk_dat({16'h0000, rx[15:0]}, 32'h0000000a);
    host.xfer(40'h44000000, 32, rx);
    chk_dat(rx[31:0], 32'h00abcdef);
    chk_st(status_o, 8'h8a);
    host.xfer(40'h4000, 16, rx);
    chk_dat({16'h0000, rx[15:0]}, 32'h0000ff8a);
    host.xfer(40'h020060, 24, rx);
    chk_st({5'h00, append_en_o, check_en_o, crc_en_o}, 8'h06);
    chk_st(status_o, 8'h8a);
    reg_sum = 16'h1235;
    repeat (3) @(negedge clock);
    chk_st(status_o, 8'h9a);
    host.xfer(40'h4000, 16, rx);
    chk_st(rx[7:0], 8'h9a);
    chk_st(status_o, 8'h9a);
    host.xfer(40'h020040, 24, rx);
    chk_st(status_o, 8'h8a);
    put_res('{1'b0, 1'b0, 24'h00ff00, 4'h5, 24'h000000, 8'h00});
    host.xfer(40'h4400000000, 40, rx);
    chk_dat(rx[31:0], 32'h00ff0005);
    chk_st(status_o, 8'h85);
    host.xfer(40'h020044, 24, rx);
    host.xfer(40'h02006400, 32, rx);
    chk_st(status_o, 8'ha5);
    chk_st({5'h00, append_en_o, check_en_o, crc_en_o}, 8'h05);
    host.xfer(40'h4000, 16, rx);
    chk_st(rx[7:0], 8'ha5);
    chk_st(status_o, 8'h85);
    cal_mode = 1'b1;
    put_res('{1'b1, 1'b0, 24'h777777, 4'h9, 24'h000000, 8'h00});
    chk_dat({8'h00, data_o}, 32'h0000ff00);
    chk_st(status_o, 8'h85);
    cal_wr = 1'b1;
    @(negedge clock);
    cal_wr = 1'b0;
    repeat (2) @(negedge clock);
    chk_st(status_o, 8'h05);
    // mid-run reset returns status and interface bits to their reset values
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk_st(status_o, 8'h80);
    chk_st({5'h00, append_en_o, check_en_o, crc_en_o}, 8'h00);
    repeat (2) @(negedge clock);
    chk_st(status_o, 8'h80);
    wrap_up();
  end
endmodule
`default_nettype wire
